// ---- id_filter_pkg.sv ----
// Constants and state layout for the message object tag and mask filter.
// Assumes an 8-bit special-function register bus local to the CPU core.
package id_filter_pkg;

  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [7:0] id_tag_reg_one    = 8'hBC;
  localparam logic [7:0] id_tag_reg_two    = 8'hBD;
  localparam logic [7:0] id_tag_reg_three  = 8'hBE;
  localparam logic [7:0] id_tag_reg_four   = 8'hBF;
  localparam logic [7:0] id_mask_reg_one   = 8'hC4;
  localparam logic [7:0] id_mask_reg_two   = 8'hC5;
  localparam logic [7:0] id_mask_reg_three = 8'hC6;
  localparam logic [7:0] id_mask_reg_four  = 8'hC7;

  // ********************************************************************
  // Field positions and readable-bit masks
  // ********************************************************************
  localparam int unsigned remote_request_pos = 2;
  localparam int unsigned reserved_bit1_pos  = 1;
  localparam int unsigned reserved_bit0_pos  = 0;
  localparam int unsigned extension_flag_pos = 0;
  localparam logic [7:0] std_byte2_keep      = 8'hE0;
  localparam logic [7:0] std_byte4_keep      = 8'h05;
  localparam logic [7:0] ext_byte4_keep      = 8'hFF;
  localparam logic [7:0] read_zero           = 8'h00;
  // Extended mask byte three lives outside this block: compare all bits
  localparam logic [7:0] ext_mask_three_fill = 8'hFF;

  // ********************************************************************
  // Reset values (the registers define none; zero keeps state known)
  // ********************************************************************
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic       flag_reset = 1'b0;

  typedef struct packed {
    logic [7:0]  tag1;
    logic [7:0]  tag2;
    logic [7:0]  tag3;
    logic [7:0]  tag4;
    logic [7:0]  mask1;
    logic [7:0]  mask2;
    logic [7:0]  mask4;
    logic [7:0]  rdata;
    logic [28:0] tx_id;
    logic        tx_rtr;
    logic        tx_rb1;
    logic        tx_rb0;
    logic        hit;
    logic        done;
  } filter_state_t;

endpackage : id_filter_pkg

// ---- id_match_if.sv ----
// Carrier between the filter register file and its acceptance comparator.
// Assumes both ends sit in the same clock domain; the bundle is purely
// combinational.
`timescale 1ns/1ps
`default_nettype none

interface id_match_if;
  logic [28:0] tag_id;
  logic [28:0] mask_id;
  logic        tag_rtr;
  logic        mask_rtr;
  logic        tag_ide;
  logic        mask_ide;
  logic [28:0] rx_id;
  logic        rx_rtr;
  logic        rx_ide;
  logic        hit;

  modport owner (
    output tag_id, mask_id, tag_rtr, mask_rtr, tag_ide, mask_ide,
    output rx_id, rx_rtr, rx_ide,
    input  hit
  );
  modport cmp (
    input  tag_id, mask_id, tag_rtr, mask_rtr, tag_ide, mask_ide,
    input  rx_id, rx_rtr, rx_ide,
    output hit
  );
endinterface : id_match_if

`default_nettype wire

// ---- id_match.sv ----
// Acceptance comparator for one message object.
// Assumes tag and mask arrive already aligned to the identifier width.
`timescale 1ns/1ps
`default_nettype none

module id_match (
  id_match_if.cmp m
);

  logic [28:0] id_diff;
  logic        rtr_diff;
  logic        ide_diff;

  // A clear mask bit forces its comparison true
  always_comb begin
    id_diff  = (m.tag_id ^ m.rx_id) & m.mask_id;
    rtr_diff = (m.tag_rtr ^ m.rx_rtr) & m.mask_rtr;
    ide_diff = (m.tag_ide ^ m.rx_ide) & m.mask_ide;
    m.hit    = (id_diff == 29'h0000000) && !rtr_diff && !ide_diff;
  end

endmodule : id_match

`default_nettype wire

// ---- can_id_tag_mask_filter.sv ----
// Tag and mask registers of one message object, with receive filtering.
// Assumes a single-cycle SFR bus on clk_sys and frames presented by the
// protocol engine as one-cycle strobes.
//
// Operation
// - Extended format tag byte one holds identifier bits 28 to 21.
// - Extended format tag byte two holds identifier bits 20 to 13.
// - Extended format tag byte three holds identifier bits 12 to 5.
// - Extended tag byte four holds id 4 to 0, remote, rb1 and rb0 tags.
// - Standard tag byte four holds only the remote tag and the rb0 tag.
// - Standard mask byte one masks identifier bits 10 to 3.
// - Standard mask byte two masks identifier bits 2 to 0 in bits 7 to 5.
// - Standard mask byte three has no functional bits.
// - Standard mask byte four has the remote mask at 2, extension mask at 0.
// - A zero mask bit forces a pass, a one requires equality.
// - Masks act only on reception; transmission uses raw tag values.
// - Standard tag bytes one and two hold identifier bits 10 to 0.
`timescale 1ns/1ps
`default_nettype none

module can_id_tag_mask_filter (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        ext_format,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        rx_valid,
  input  wire logic [28:0] rx_id,
  input  wire logic        rx_rtr,
  input  wire logic        rx_ide,
  output logic             rx_done,
  output logic             rx_hit,
  output logic      [28:0] tx_id,
  output logic             tx_rtr,
  output logic             tx_rb1,
  output logic             tx_rb0
);

  // ********************************************************************
  // State
  // ********************************************************************
  id_filter_pkg::filter_state_t st;
  id_filter_pkg::filter_state_t next_st;

  id_match_if mif ();

  id_match u_match (
    .m (mif)
  );

  // ********************************************************************
  // Comparator feed
  // ********************************************************************
  always_comb begin
    if (ext_format) begin
      mif.tag_id  = {st.tag1, st.tag2, st.tag3, st.tag4[7:3]};
      mif.mask_id = {st.mask1, st.mask2,
                     id_filter_pkg::ext_mask_three_fill, st.mask4[7:3]};
      mif.rx_id   = rx_id;
    end else begin
      mif.tag_id  = {18'h00000, st.tag1, st.tag2[7:5]};
      mif.mask_id = {18'h00000, st.mask1, st.mask2[7:5]};
      mif.rx_id   = {18'h00000, rx_id[10:0]};
    end
    mif.tag_rtr  = st.tag4[id_filter_pkg::remote_request_pos];
    mif.mask_rtr = st.mask4[id_filter_pkg::remote_request_pos];
    mif.tag_ide  = ext_format;
    mif.mask_ide = st.mask4[id_filter_pkg::extension_flag_pos];
    mif.rx_rtr   = rx_rtr;
    mif.rx_ide   = rx_ide;
  end

  // ********************************************************************
  // Register file, read mux and outputs
  // ********************************************************************
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (sfr_wr) begin
      // Reserved bits are stored as written; software keeps them zero
      unique case (sfr_addr)
        id_filter_pkg::id_tag_reg_one:   next_st.tag1  = sfr_wdata;
        id_filter_pkg::id_tag_reg_two:   next_st.tag2  = sfr_wdata;
        id_filter_pkg::id_tag_reg_three: next_st.tag3  = sfr_wdata;
        id_filter_pkg::id_tag_reg_four:  next_st.tag4  = sfr_wdata;
        id_filter_pkg::id_mask_reg_one:  next_st.mask1 = sfr_wdata;
        id_filter_pkg::id_mask_reg_two:  next_st.mask2 = sfr_wdata;
        id_filter_pkg::id_mask_reg_four: next_st.mask4 = sfr_wdata;
        default:                         next_st.tag1  = st.tag1;
      endcase
    end
    if (sfr_rd) begin
      // Reserved positions read zero so nothing stale leaks to software
      unique case (sfr_addr)
        id_filter_pkg::id_tag_reg_one:
          next_st.rdata = st.tag1;
        id_filter_pkg::id_tag_reg_two:
          next_st.rdata = ext_format ? st.tag2 :
                          (st.tag2 & id_filter_pkg::std_byte2_keep);
        id_filter_pkg::id_tag_reg_three:
          next_st.rdata = ext_format ? st.tag3 : id_filter_pkg::read_zero;
        id_filter_pkg::id_tag_reg_four:
          next_st.rdata = st.tag4 & (ext_format ?
                          id_filter_pkg::ext_byte4_keep :
                          id_filter_pkg::std_byte4_keep);
        id_filter_pkg::id_mask_reg_one:
          next_st.rdata = st.mask1;
        id_filter_pkg::id_mask_reg_two:
          next_st.rdata = st.mask2 & id_filter_pkg::std_byte2_keep;
        id_filter_pkg::id_mask_reg_four:
          next_st.rdata = st.mask4 & id_filter_pkg::std_byte4_keep;
        default:
          next_st.rdata = id_filter_pkg::read_zero;
      endcase
    end
    // Transmit fields bypass the masks entirely
    next_st.tx_id  = mif.tag_id;
    next_st.tx_rtr = st.tag4[id_filter_pkg::remote_request_pos];
    next_st.tx_rb1 = ext_format &
                     st.tag4[id_filter_pkg::reserved_bit1_pos];
    next_st.tx_rb0 = st.tag4[id_filter_pkg::reserved_bit0_pos];
    if (rx_valid) begin
      next_st.hit  = mif.hit;
      next_st.done = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '{tag1:   id_filter_pkg::byte_reset,
              tag2:   id_filter_pkg::byte_reset,
              tag3:   id_filter_pkg::byte_reset,
              tag4:   id_filter_pkg::byte_reset,
              mask1:  id_filter_pkg::byte_reset,
              mask2:  id_filter_pkg::byte_reset,
              mask4:  id_filter_pkg::byte_reset,
              rdata:  id_filter_pkg::byte_reset,
              tx_id:  29'h00000000,
              tx_rtr: id_filter_pkg::flag_reset,
              tx_rb1: id_filter_pkg::flag_reset,
              tx_rb0: id_filter_pkg::flag_reset,
              hit:    id_filter_pkg::flag_reset,
              done:   id_filter_pkg::flag_reset};
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata = st.rdata;
  assign rx_done   = st.done;
  assign rx_hit    = st.hit;
  assign tx_id     = st.tx_id;
  assign tx_rtr    = st.tx_rtr;
  assign tx_rb1    = st.tx_rb1;
  assign tx_rb0    = st.tx_rb0;

  // ********************************************************************
  // Checks
  // ********************************************************************
  AST_EXT_TX_ID: assert property (@(posedge clk_sys) disable iff (reset)
    ext_format && !sfr_wr ##1 ext_format && !sfr_wr
    |=> tx_id == {$past(st.tag1), $past(st.tag2), $past(st.tag3),
                  $past(st.tag4[7:3])})
    else $error("extended transmit identifier does not follow tag bytes");

  AST_EXT_TAG3_READ: assert property (@(posedge clk_sys) disable iff (reset)
    sfr_wr && sfr_addr == id_filter_pkg::id_tag_reg_three
    ##1 sfr_rd && !sfr_wr && ext_format
        && sfr_addr == id_filter_pkg::id_tag_reg_three
    |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("tag byte three does not read back in extended format");

  AST_STD_TX_ID: assert property (@(posedge clk_sys) disable iff (reset)
    !ext_format && !sfr_wr
    |=> tx_id[10:0] == {$past(st.tag1), $past(st.tag2[7:5])}
        && tx_id[28:11] == 18'h00000)
    else $error("standard transmit identifier wrong");

  AST_STD_TAG4_READ: assert property (@(posedge clk_sys) disable iff (reset)
    sfr_rd && !ext_format && sfr_addr == id_filter_pkg::id_tag_reg_four
    |=> sfr_rdata[7:3] == 5'h00 && sfr_rdata[1] == 1'b0)
    else $error("reserved bits of standard tag byte four read nonzero");

  AST_MASK1_READ: assert property (@(posedge clk_sys) disable iff (reset)
    sfr_wr && sfr_addr == id_filter_pkg::id_mask_reg_one
    ##1 sfr_rd && !sfr_wr && sfr_addr == id_filter_pkg::id_mask_reg_one
    |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("mask byte one does not read back");

  AST_MASK2_READ: assert property (@(posedge clk_sys) disable iff (reset)
    sfr_rd && sfr_addr == id_filter_pkg::id_mask_reg_two
    |=> sfr_rdata[4:0] == 5'h00)
    else $error("reserved bits of mask byte two read nonzero");

  AST_MASK3_READ: assert property (@(posedge clk_sys) disable iff (reset)
    sfr_rd && sfr_addr == id_filter_pkg::id_mask_reg_three
    |=> sfr_rdata == 8'h00)
    else $error("mask byte three reads nonzero");

  AST_MASK4_READ: assert property (@(posedge clk_sys) disable iff (reset)
    sfr_wr && sfr_addr == id_filter_pkg::id_mask_reg_four
    ##1 sfr_rd && !sfr_wr && sfr_addr == id_filter_pkg::id_mask_reg_four
    |=> sfr_rdata == ($past(sfr_wdata, 2) & id_filter_pkg::std_byte4_keep))
    else $error("mask byte four read back wrong");

  AST_ZERO_MASK_PASS: assert property (@(posedge clk_sys) disable iff (reset)
    rx_valid && mif.mask_id == 29'h00000000 && !mif.mask_rtr
    && !mif.mask_ide
    |=> rx_done && rx_hit)
    else $error("all-clear mask did not accept the frame");

  AST_EXACT_HIT: assert property (@(posedge clk_sys) disable iff (reset)
    !sfr_wr ##1 !sfr_wr ##1 rx_valid && !sfr_wr && rx_id == tx_id
    && rx_rtr == tx_rtr && rx_ide == ext_format && $stable(ext_format)
    |=> rx_done && rx_hit)
    else $error("frame equal to the tags was not accepted");

  AST_RTR_MISS: assert property (@(posedge clk_sys) disable iff (reset)
    rx_valid && mif.mask_rtr && (rx_rtr != mif.tag_rtr)
    |=> rx_done && !rx_hit)
    else $error("enabled remote-request mismatch was accepted");

  AST_DONE_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
    rx_done |-> $past(rx_valid))
    else $error("receive done without a frame strobe");

endmodule : can_id_tag_mask_filter

`default_nettype wire

// ---- can_node_model.sv ----
// Remote node model: hands received frames to the filter as strobes.
// Assumes the filter samples a frame at the clk_sys edge with rx_valid high.
`timescale 1ns/1ps
`default_nettype none

module can_node_model (
  input  wire logic        clk_sys,
  output var  logic        rx_valid,
  output var  logic [28:0] rx_id,
  output var  logic        rx_rtr,
  output var  logic        rx_ide
);
  initial begin
    rx_valid = 1'b0;
    rx_id    = 29'h0;
    rx_rtr   = 1'b0;
    rx_ide   = 1'b0;
  end

  // Between strobes the fields carry the inverse of the last frame, so a
  // filter that samples at the wrong edge sees wrong values
  task automatic send(input logic [28:0] id, input logic rtr, ide);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_id    <= id;
    rx_rtr   <= rtr;
    rx_ide   <= ide;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_id    <= ~id;
    rx_rtr   <= ~rtr;
    rx_ide   <= ~ide;
  endtask : send
endmodule : can_node_model

`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the tag and mask filter.
// Assumes the filter and the remote node model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk_sys;
  logic        reset;
  logic        ext_format;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        rx_valid;
  logic [28:0] rx_id;
  logic        rx_rtr;
  logic        rx_ide;
  logic        rx_done;
  logic        rx_hit;
  logic [28:0] tx_id;
  logic        tx_rtr;
  logic        tx_rb1;
  logic        tx_rb0;
  logic [28:0] tid;
  logic [28:0] mid;
  logic        trtr;
  logic        mrtr;
  logic        mide;
  int          fail_count;
  int          n_compared;

  can_id_tag_mask_filter u_can_id_tag_mask_filter (
    .clk_sys, .reset, .ext_format, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .rx_valid, .rx_id, .rx_rtr, .rx_ide,
    .rx_done, .rx_hit, .tx_id, .tx_rtr, .tx_rb1, .tx_rb0
  );
  can_node_model u_can_node_model (
    .clk_sys, .rx_valid, .rx_id, .rx_rtr, .rx_ide
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ********************************************************************
  // Access and compare tasks
  // ********************************************************************
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk_sys);
    sfr_wr    <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, exp);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk_sys);
    sfr_rd   <= 1'b0;
    #1;
    chk($sformatf("reg %0h", a), {24'h0, exp}, {24'h0, sfr_rdata});
  endtask : rdc

  // Write, then read the same byte on the very next edge
  task automatic wr_rd(input logic [7:0] a, d, exp);
    @(posedge clk_sys);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk_sys);
    sfr_wr    <= 1'b0;
    sfr_rd    <= 1'b1;
    @(posedge clk_sys);
    sfr_rd    <= 1'b0;
    #1;
    chk($sformatf("reg %0h", a), {24'h0, exp}, {24'h0, sfr_rdata});
  endtask : wr_rd

  task automatic txc(input logic [28:0] id, input logic [2:0] f);
    @(posedge clk_sys);
    #1;
    chk("tx_id", {3'h0, id}, {3'h0, tx_id});
    chk("tx flags", {29'h0, f}, {29'h0, tx_rtr, tx_rb1, tx_rb0});
  endtask : txc

  task automatic frame(input logic [28:0] id, input logic rtr, ide);
    logic exp;
    exp = (((id ^ tid) & mid) == 29'h0) && !((rtr ^ trtr) & mrtr)
          && !((ide ^ ext_format) & mide);
    u_can_node_model.send(id, rtr, ide);
    #1;
    chk("rx_done", 32'h1, {31'h0, rx_done});
    chk("rx_hit", {31'h0, exp}, {31'h0, rx_hit});
  endtask : frame

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // ********************************************************************
  // Tests
  // ********************************************************************
  logic [7:0]  adr [8] = '{8'hBC, 8'hBD, 8'hBE, 8'hBF,
                           8'hC4, 8'hC5, 8'hC6, 8'hC7};
  logic [7:0]  sv_std [8] = '{8'hA5, 8'hC0, 8'h00, 8'h05,
                              8'hF0, 8'hE0, 8'h00, 8'h05};
  logic [7:0]  sv_ext [8] = '{8'h9C, 8'h3A, 8'h5E, 8'hAB,
                              8'hFF, 8'h0F, 8'h00, 8'h04};
  logic [28:0] fl_std [4] = '{29'h0, 29'h078, 29'h001, 29'h400};
  logic [28:0] fl_ext [5] = '{29'h0, 29'h100000, 29'h10000, 29'h1, 29'h100};

  initial begin
    fail_count = 0;
    n_compared = 0;
    reset      = 1'b1;
    ext_format = 1'b0;
    sfr_addr   = 8'h00;
    sfr_wr     = 1'b0;
    sfr_rd     = 1'b0;
    sfr_wdata  = 8'h00;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    // Every field written before use, reserved bits written as zero
    foreach (adr[i]) wr(adr[i], sv_std[i]);
    foreach (adr[i]) rdc(adr[i], sv_std[i]);
    wr(8'hC0, 8'h5A);
    rdc(8'hC0, 8'h00);
    txc({18'h0, 8'hA5, 3'h6}, 3'h5);
    tid  = {18'h0, 8'hA5, 3'h6};
    mid  = {18'h0, 8'hF0, 3'h7};
    trtr = 1'b1;
    mrtr = 1'b1;
    mide = 1'b1;
    foreach (fl_std[i]) frame(tid ^ fl_std[i], 1'b1, 1'b0);
    frame(tid, 1'b0, 1'b0);
    frame(tid, 1'b1, 1'b1);
    wr_rd(8'hC4, 8'h00, 8'h00);
    wr(8'hC5, 8'h00);
    wr_rd(8'hC7, 8'h00, 8'h00);
    {mid, mrtr, mide} = '0;
    frame(tid ^ 29'h7FF, 1'b0, 1'b1);
    txc({18'h0, 8'hA5, 3'h6}, 3'h5);
    $display("standard format test done");
    @(posedge clk_sys);
    ext_format <= 1'b1;
    foreach (adr[i]) wr(adr[i], sv_ext[i]);
    wr_rd(8'hBE, 8'h5E, 8'h5E);
    for (int i = 0; i < 4; i++) rdc(adr[i], sv_ext[i]);
    txc({8'h9C, 8'h3A, 8'h5E, 5'h15}, 3'h3);
    tid  = {8'h9C, 8'h3A, 8'h5E, 5'h15};
    mid  = {8'hFF, 8'h0F, 8'hFF, 5'h00};
    trtr = 1'b0;
    mrtr = 1'b1;
    mide = 1'b0;
    foreach (fl_ext[i]) frame(tid ^ fl_ext[i], 1'b0, 1'b1);
    frame(tid, 1'b1, 1'b1);
    frame(tid, 1'b0, 1'b0);
    $display("extended format test done");
    conclude();
  end

  initial begin
    #20000;
    fail_count++;
    $display("watchdog expired");
    conclude();
  end
endmodule : tb

`default_nettype wire
